// ### common/prs1_pkg.sv
// Purpose: shared constants and carrier types of the pin remap selector
// Assumes: one 8-bit selector register on a plain strobe port
// Notes:   bit positions and variant masks are used by the remap core only through these names

// ==========================================================
// package
package prs1_pkg;

  // register port geometry
  localparam int         ADDR_W    = 4;
  localparam int         DATA_W    = 8;
  localparam logic [3:0] REG_OFF   = 4'h0;   // selector register offset
  localparam logic [7:0] SEL_RESET = 8'h00;  // every function on its primary pin
  localparam logic [7:0] RD_IDLE   = 8'h00;  // read data outside a read answer

  // selector field positions
  localparam int BIT_TMR1B_OUT0 = 0;
  localparam int BIT_TMR1B_OUT1 = 1;
  localparam int BIT_IRQ0       = 2;
  localparam int BIT_IRQ1       = 3;
  localparam int BIT_IRQ2       = 4;
  localparam int BIT_TIMER_CLK_IN_ZERO       = 5;
  localparam int BIT_TIMER_CLK_IN_ONE       = 6;
  localparam int BIT_TIMER_CLK_IN_TWO       = 7;

  // implemented bits per device variant
  localparam logic [7:0] MASK_SMALL = 8'h6F;
  localparam logic [7:0] MASK_MID   = 8'hEF;
  localparam logic [7:0] MASK_LARGE = 8'hFF;

  typedef enum logic [1:0] {
    PRS1_SMALL = 2'b00,
    PRS1_MID   = 2'b01,
    PRS1_LARGE = 2'b10
  } prs1_variant_t;

  // register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } prs1_bus_t;

  // pad levels feeding remapped inputs
  typedef struct packed {
    logic irq2_loc_alt;
    logic irq2_loc_dflt;
    logic port_e_line_5;
    logic port_e_line_4;
    logic port_e_line_2;
    logic port_e_line_1;
    logic port_e_line_0;
    logic port_c_line_2;
    logic port_a_line_4;
    logic port_a_line_3;
    logic port_a_line_2;
  } prs1_pins_in_t;

  localparam int SYNC_W = $bits(prs1_pins_in_t);

  // remapped inputs handed to the timers and interrupt logic
  typedef struct packed {
    logic ext_irq_in_two;
    logic ext_irq_in_one;
    logic ext_irq_in_zero;
    logic timer_clk_in_two;
    logic timer_clk_in_one;
    logic timer_clk_in_zero;
  } prs1_periph_t;

  // pads that may carry timer one output b
  typedef struct packed {
    logic port_d_line_4;
    logic port_d_line_3;
    logic port_c_line_1;
    logic port_c_line_0;
  } prs1_pin_drv_t;

endpackage : prs1_pkg

// ### rtl/prs1_sync.sv
// Purpose: two-stage synchroniser for the pad inputs of the remap core
// Assumes: pads are asynchronous to sys_clk
// Notes:   first stage is read only by the second stage

`timescale 1ns/100ps

module prs1_sync (
  input  wire logic                      sys_clk,
  input  wire logic                      rst_n,
  input  wire logic                      ce,
  input  wire logic [prs1_pkg::SYNC_W-1:0] async_in,
  output logic      [prs1_pkg::SYNC_W-1:0] sync_out
);
  import prs1_pkg::*;

  typedef struct packed {
    logic [SYNC_W-1:0] meta;
    logic [SYNC_W-1:0] stable;
  } prs1_sync_state_t;

  prs1_sync_state_t r;
  prs1_sync_state_t next_r;

  // ==========================================================
  // next state: shift pads through two stages
  always_comb begin
    next_r        = r;
    next_r.meta   = async_in;
    next_r.stable = r.meta;
  end

  // clock enable low freezes both stages
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign sync_out = r.stable;

endmodule : prs1_sync

// ### rtl/prs1_remap.sv
// Purpose: pin remap selector one, steering timer clocks, external
//          interrupts and timer one output b between two pad locations
// Assumes: pads asynchronous, timer one outputs synchronous to sys_clk
// Notes:   unimplemented selector bits depend on the variant parameter
//
// Local design decisions: the register addresses and the strobed register port.

`timescale 1ns/100ps

// Functional notes
// R1 - Timer clock input zero comes from port A line 2 when bit 5 is 0, else from port E line 0.
// R2 - Timer clock input one comes from port A line 4 when bit 6 is 0, else from port E line 1.
// R3 - In mid and large variants timer clock input two comes from port C line 2 when bit 7 is 0, else port E line 2.
// R4 - External interrupt input one comes from port A line 4 when bit 3 is 0, else from port E line 5.
// R5 - External interrupt input zero comes from port A line 3 when bit 2 is 0, else from port E line 4.
// R6 - Timer one output b channel 1 drives port C line 1 when bit 1 is 0, else port D line 4.
// R7 - Timer one output b channel 0 drives port C line 0 when bit 0 is 0, else port D line 3.
// R8 - Unimplemented bits read as zero and ignore writes: bits 7 and 4 when small, bit 4 when mid.
// R9 - In the large variant bit 4 picks the default or alternate pad for external interrupt input two.
// R10 - Implemented bits are read and write and clear to zero at reset.
module prs1_remap #(
  parameter prs1_pkg::prs1_variant_t VARIANT = prs1_pkg::PRS1_LARGE
) (
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  input  wire logic                    ce,
  input  wire prs1_pkg::prs1_bus_t     bus,
  output logic [prs1_pkg::DATA_W-1:0]  read_data,
  input  wire prs1_pkg::prs1_pins_in_t pins_in,
  input  wire logic                    timer1_out_b_ch0,
  input  wire logic                    timer1_out_b_ch1,
  output prs1_pkg::prs1_periph_t       periph,
  output prs1_pkg::prs1_pin_drv_t      pin_out,
  output prs1_pkg::prs1_pin_drv_t      pin_oe
);
  import prs1_pkg::*;

  // implemented bits of this variant
  localparam logic [7:0] IMPL_MASK = (VARIANT == PRS1_SMALL) ? MASK_SMALL :
                                     (VARIANT == PRS1_MID)   ? MASK_MID   : MASK_LARGE;

  typedef struct packed {
    logic [7:0]    sel;
    logic [7:0]    read_data;
    prs1_periph_t  periph;
    prs1_pin_drv_t pin_out;
    prs1_pin_drv_t pin_oe;
  } prs1_state_t;

  prs1_state_t   r;
  prs1_state_t   next_r;
  prs1_pins_in_t syn;

  // ==========================================================
  // pad synchroniser
  prs1_sync u_sync (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .async_in (pins_in),
    .sync_out (syn)
  );

  // ==========================================================
  // register port and routing
  // routing reads the stored selector, so a write takes effect one cycle
  // after the write strobe; this keeps every output a clean flop
  always_comb begin
    next_r = r;
    // write: only implemented bits are stored
    if (bus.wr && bus.addr == REG_OFF) begin
      next_r.sel = bus.wdata & IMPL_MASK; // R8 R10
    end
    // read answer stands for one cycle only; unmapped address reads zero
    next_r.read_data = RD_IDLE;
    if (bus.rd && bus.addr == REG_OFF) begin
      next_r.read_data = r.sel; // R8 R10
    end

    // input remapping
    next_r.periph.timer_clk_in_zero = r.sel[BIT_TIMER_CLK_IN_ZERO] ? syn.port_e_line_0 : syn.port_a_line_2; // R1
    next_r.periph.timer_clk_in_one  = r.sel[BIT_TIMER_CLK_IN_ONE] ? syn.port_e_line_1 : syn.port_a_line_4; // R2
    // the small variant has no third timer clock; hold it low
    next_r.periph.timer_clk_in_two  = IMPL_MASK[BIT_TIMER_CLK_IN_TWO] ?
                                      (r.sel[BIT_TIMER_CLK_IN_TWO] ? syn.port_e_line_2 : syn.port_c_line_2) : 1'b0; // R3
    next_r.periph.ext_irq_in_one    = r.sel[BIT_IRQ1] ? syn.port_e_line_5 : syn.port_a_line_4; // R4
    next_r.periph.ext_irq_in_zero   = r.sel[BIT_IRQ0] ? syn.port_e_line_4 : syn.port_a_line_3; // R5
    // third interrupt exists only in the large variant
    next_r.periph.ext_irq_in_two    = IMPL_MASK[BIT_IRQ2] ?
                                      (r.sel[BIT_IRQ2] ? syn.irq2_loc_alt : syn.irq2_loc_dflt) : 1'b0; // R9

    // output remapping: the unused pad is released, not driven low
    next_r.pin_oe.port_c_line_1  = ~r.sel[BIT_TMR1B_OUT1]; // R6
    next_r.pin_oe.port_d_line_4  =  r.sel[BIT_TMR1B_OUT1]; // R6
    next_r.pin_out.port_c_line_1 = ~r.sel[BIT_TMR1B_OUT1] & timer1_out_b_ch1; // R6
    next_r.pin_out.port_d_line_4 =  r.sel[BIT_TMR1B_OUT1] & timer1_out_b_ch1; // R6
    next_r.pin_oe.port_c_line_0  = ~r.sel[BIT_TMR1B_OUT0]; // R7
    next_r.pin_oe.port_d_line_3  =  r.sel[BIT_TMR1B_OUT0]; // R7
    next_r.pin_out.port_c_line_0 = ~r.sel[BIT_TMR1B_OUT0] & timer1_out_b_ch0; // R7
    next_r.pin_out.port_d_line_3 =  r.sel[BIT_TMR1B_OUT0] & timer1_out_b_ch0; // R7
  end

  // ==========================================================
  // state register; clock enable low freezes everything
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      r     <= '0;
      r.sel <= SEL_RESET; // R10
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign read_data = r.read_data;
  assign periph    = r.periph;
  assign pin_out   = r.pin_out;
  assign pin_oe    = r.pin_oe;

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  timer_clk_in_zero_route_a: assert property ($past(ce) |-> periph.timer_clk_in_zero == // R1
      ($past(r.sel[BIT_TIMER_CLK_IN_ZERO]) ? $past(syn.port_e_line_0) : $past(syn.port_a_line_2)))
    else $error("timer clock zero not on selected pad");

  timer_clk_in_one_route_a: assert property ($past(ce) |-> periph.timer_clk_in_one == // R2
      ($past(r.sel[BIT_TIMER_CLK_IN_ONE]) ? $past(syn.port_e_line_1) : $past(syn.port_a_line_4)))
    else $error("timer clock one not on selected pad");

  timer_clk_in_two_route_a: assert property ($past(ce) && IMPL_MASK[BIT_TIMER_CLK_IN_TWO] |-> periph.timer_clk_in_two == // R3
      ($past(r.sel[BIT_TIMER_CLK_IN_TWO]) ? $past(syn.port_e_line_2) : $past(syn.port_c_line_2)))
    else $error("timer clock two not on selected pad");

  irq1_route_a: assert property ($past(ce) |-> periph.ext_irq_in_one == // R4
      ($past(r.sel[BIT_IRQ1]) ? $past(syn.port_e_line_5) : $past(syn.port_a_line_4)))
    else $error("interrupt one not on selected pad");

  irq0_route_a: assert property ($past(ce) |-> periph.ext_irq_in_zero == // R5
      ($past(r.sel[BIT_IRQ0]) ? $past(syn.port_e_line_4) : $past(syn.port_a_line_3)))
    else $error("interrupt zero not on selected pad");

  out1_route_a: assert property ($past(ce) && $past(rst_n) |-> // R6
      (pin_oe.port_d_line_4 == $past(r.sel[BIT_TMR1B_OUT1])) && (pin_oe.port_c_line_1 != pin_oe.port_d_line_4)
      && ((pin_out.port_c_line_1 | pin_out.port_d_line_4) == $past(timer1_out_b_ch1)))
    else $error("timer one b channel 1 on wrong pad");

  out0_route_a: assert property ($past(ce) && $past(rst_n) |-> // R7
      (pin_oe.port_d_line_3 == $past(r.sel[BIT_TMR1B_OUT0])) && (pin_oe.port_c_line_0 != pin_oe.port_d_line_3)
      && ((pin_out.port_c_line_0 | pin_out.port_d_line_3) == $past(timer1_out_b_ch0)))
    else $error("timer one b channel 0 on wrong pad");

  unimpl_zero_a: assert property ((read_data & ~IMPL_MASK) == 8'h00 && (r.sel & ~IMPL_MASK) == 8'h00) // R8
    else $error("unimplemented selector bit is set");

  irq2_route_a: assert property ($past(ce) |-> periph.ext_irq_in_two == // R9
      (IMPL_MASK[BIT_IRQ2] ? ($past(r.sel[BIT_IRQ2]) ? $past(syn.irq2_loc_alt) : $past(syn.irq2_loc_dflt)) : 1'b0))
    else $error("interrupt two not on selected pad");

  reg_write_a: assert property (ce && bus.wr && bus.addr == REG_OFF ##1 ce && bus.rd && bus.addr == REG_OFF // R10
      |=> read_data == ($past(bus.wdata, 2) & IMPL_MASK))
    else $error("selector readback differs from written value");

  read_pulse_a: assert property ($past(ce) && !$past(bus.rd) |-> read_data == RD_IDLE) // R10
    else $error("read data outside read answer");

endmodule : prs1_remap

// ### test/tb_top.sv
// Purpose: self-checking bench for the pin remap selector, large, mid and small variants side by side
// Assumes: strobe port with read data one cycle after the read strobe, pads held steady while compared
// Notes:   model recomputes routing from the selector value and pad levels, never from design outputs

`timescale 1ns/100ps

// ==========================================================
// bench top
module tb_top;
  import prs1_pkg::*;

  logic          sys_clk;
  logic          rst_n;
  logic          ce;
  prs1_bus_t     bus;
  prs1_pins_in_t pins_in;
  logic          ch0;
  logic          ch1;
  logic [7:0]    rd_l;
  logic [7:0]    rd_s;
  logic [7:0]    rd_m;
  prs1_periph_t  per_l;
  prs1_periph_t  per_s;
  prs1_periph_t  per_m;
  prs1_pin_drv_t out_m;
  prs1_pin_drv_t oe_m;
  prs1_pin_drv_t out_l;
  prs1_pin_drv_t oe_l;
  prs1_pin_drv_t out_s;
  prs1_pin_drv_t oe_s;
  logic [7:0]    sel;
  int            error_cnt;
  int            samples_checked;
  int            seed;

  // all three variants see the same stimulus so the mask difference shows directly
  prs1_remap #(.VARIANT(PRS1_LARGE)) uut (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .bus(bus),
    .read_data(rd_l), .pins_in(pins_in), .timer1_out_b_ch0(ch0), .timer1_out_b_ch1(ch1),
    .periph(per_l), .pin_out(out_l), .pin_oe(oe_l));
  prs1_remap #(.VARIANT(PRS1_SMALL)) uut_small (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .bus(bus),
    .read_data(rd_s), .pins_in(pins_in), .timer1_out_b_ch0(ch0), .timer1_out_b_ch1(ch1),
    .periph(per_s), .pin_out(out_s), .pin_oe(oe_s));
  // middle variant keeps the third timer clock but has no third interrupt
  prs1_remap #(.VARIANT(PRS1_MID)) uut_mid (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .bus(bus),
    .read_data(rd_m), .pins_in(pins_in), .timer1_out_b_ch0(ch0), .timer1_out_b_ch1(ch1),
    .periph(per_m), .pin_out(out_m), .pin_oe(oe_m));

  // 20 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // ==========================================================
  // model and checks
  task automatic check(logic [15:0] seen, logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check

  // absent functions drive 0, so the mask gates the optional inputs
  function automatic prs1_periph_t exp_per(logic [7:0] s, logic [7:0] m);
    prs1_periph_t e;
    e.timer_clk_in_zero = s[BIT_TIMER_CLK_IN_ZERO] ? pins_in.port_e_line_0 : pins_in.port_a_line_2;
    e.timer_clk_in_one  = s[BIT_TIMER_CLK_IN_ONE] ? pins_in.port_e_line_1 : pins_in.port_a_line_4;
    e.timer_clk_in_two  = m[BIT_TIMER_CLK_IN_TWO] & (s[BIT_TIMER_CLK_IN_TWO] ? pins_in.port_e_line_2 : pins_in.port_c_line_2);
    e.ext_irq_in_one    = s[BIT_IRQ1] ? pins_in.port_e_line_5 : pins_in.port_a_line_4;
    e.ext_irq_in_zero   = s[BIT_IRQ0] ? pins_in.port_e_line_4 : pins_in.port_a_line_3;
    e.ext_irq_in_two    = m[BIT_IRQ2] & (s[BIT_IRQ2] ? pins_in.irq2_loc_alt : pins_in.irq2_loc_dflt);
    return e;
  endfunction : exp_per

  // order d4, d3, c1, c0: the unselected pad is released
  function automatic logic [3:0] exp_oe(logic [7:0] s);
    return {s[1], s[0], ~s[1], ~s[0]};
  endfunction : exp_oe

  task automatic compare_all();
    check({per_l, oe_l, out_l}, {exp_per(sel & MASK_LARGE, MASK_LARGE), exp_oe(sel),
      exp_oe(sel) & {ch1, ch0, ch1, ch0}});
    check({per_s, oe_s, out_s}, {exp_per(sel & MASK_SMALL, MASK_SMALL), exp_oe(sel),
      exp_oe(sel) & {ch1, ch0, ch1, ch0}});
    check({per_m, oe_m, out_m}, {exp_per(sel & MASK_MID, MASK_MID), exp_oe(sel),
      exp_oe(sel) & {ch1, ch0, ch1, ch0}});
  endtask : compare_all

  // ==========================================================
  // register port
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus.wr <= 1'b0;
  endtask : wr

  // read answer stands one cycle only, then the idle value returns
  task automatic rd_answer(logic [7:0] el, logic [7:0] es);
    @(posedge sys_clk);
    bus.rd <= 1'b0;
    #1;
    check({rd_l, rd_s}, {el, es});
    check(16'(rd_m), 16'(el & MASK_MID));
    @(posedge sys_clk);
    #1;
    check({rd_l, rd_s}, {RD_IDLE, RD_IDLE});
    check(16'(rd_m), 16'(RD_IDLE));
  endtask : rd_answer

  task automatic rd(logic [3:0] a, logic [7:0] el, logic [7:0] es);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    rd_answer(el, es);
  endtask : rd

  // write strobe followed by read strobe with no gap: readback must show the new value
  task automatic wr_rd(logic [3:0] a, logic [7:0] d, logic [7:0] el, logic [7:0] es);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    rd_answer(el, es);
  endtask : wr_rd

  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up

  // ==========================================================
  // main sequence
  initial begin
    seed = 88;
    error_cnt = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    ce = 1'b1;
    bus = '0;
    pins_in = '0;
    ch0 = 1'b0;
    ch1 = 1'b0;
    sel = SEL_RESET;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(REG_OFF, SEL_RESET, SEL_RESET);
    compare_all();
    // random selector and pad patterns; settle past the two-stage synchroniser
    for (int i = 0; i < 40; i++) begin
      sel = 8'($random(seed));
      if (i % 2 == 1) begin
        wr_rd(REG_OFF, sel, sel & MASK_LARGE, sel & MASK_SMALL);
      end else begin
        wr(REG_OFF, sel);
        rd(REG_OFF, sel & MASK_LARGE, sel & MASK_SMALL);
      end
      @(posedge sys_clk);
      pins_in <= SYNC_W'($random(seed));
      {ch1, ch0} <= 2'($random(seed));
      repeat (4) @(posedge sys_clk);
      #1;
      compare_all();
    end
    // unmapped place ignores writes and reads as zero
    wr(4'h5, 8'hFF);
    rd(4'h5, 8'h00, 8'h00);
    rd(REG_OFF, sel & MASK_LARGE, sel & MASK_SMALL);
    // a write while the clock enable is low is lost
    @(posedge sys_clk);
    ce <= 1'b0;
    wr(REG_OFF, ~sel);
    ce <= 1'b1;
    rd(REG_OFF, sel & MASK_LARGE, sel & MASK_SMALL);
    // second reset in mid-run returns every function to its primary pad
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    sel = SEL_RESET;
    rd(REG_OFF, SEL_RESET, SEL_RESET);
    repeat (4) @(posedge sys_clk);
    #1;
    compare_all();
    wrap_up();
  end

  // watchdog far beyond the roughly 420 cycles the sequence needs
  initial begin
    #2000000;
    error_cnt++;
    wrap_up();
  end

endmodule : tb_top
